// ### spm_ctrl.sv
// Mode, reference run and status control of the stepper positioning card
// Function
// R1: Fault output high only while an error exists and mode is automatic.
// R2: Error state holds until acknowledged; the outside party must acknowledge.
// R3: Closed-end output high while position equals the closed end.
// R4: Open-end output high while position equals the open end.
// R5: First preset output high while position equals first preset.
// R6: Second preset output high while position equals second preset.
// R7: Unresponsive output high whenever external control inputs are ignored.
// R8: Mode set by panel switch or tool; tool selection overrides switch.
// R9: A configuration bit locks out the panel mode switch.
// R10: Exactly one of manual or automatic indicator is lit.
// R11: Manual mode ignores all master control position commands.
// R12: Manual mode moves open or closed by the panel buttons.
// R13: Configuration writes accepted only in manual mode.
// R14: Automatic mode takes its target from the master control inputs.
// R15: Automatic mode ignores panel buttons and rejects configuration writes.
// R16: Every power-up and reset starts a reference run before positioning.
// R17: Reference run ending in automatic goes to the commanded position.
// R18: Reference run ending in manual parks mixer open, throttle closed.
// R19: During reference run inputs are ignored, unresponsive output is active.
// R20: The configuration tool can start a reference run.
// R21: Reset input held high at least 50 ms clears error, restarts reference.
// R22: Both preset requests active gives the first preset priority.
// R23: Never move past the end positions; clamp commands pushing further.
`include "spm_params.svh"
module spm_ctrl #(
	parameter int               POS_W    = `SPM_POS_W,
	parameter logic [POS_W-1:0] OPEN_POS = `SPM_OPEN_POS,
	parameter int               STEP_CYC = `SPM_STEP_CYC,
	parameter int               HOLD_CYC = `SPM_RST_HOLD_CYC
) (
	input  wire logic               mclk,                 // System clock, 100 MHz
	input  wire logic               rst_n,                // Asynchronous reset, active low
	input  wire logic               ext_reset,            // Reset input from the master control
	input  wire logic               mode_switch_auto,     // Panel switch, high selects automatic
	input  wire logic               tool_mode_set,        // Tool mode selection strobe
	input  wire logic               tool_mode_auto,       // Mode chosen by the tool
	input  wire logic               tool_ref_run,         // Tool request for a reference run
	input  wire logic               cfg_wr,               // Configuration write strobe
	input  spm_pkg::spm_cfg_sel_t   cfg_sel,              // Configuration item selected
	input  wire logic [POS_W-1:0]   cfg_data,             // Configuration value
	input  wire logic               btn_open,             // Panel open button
	input  wire logic               btn_close,            // Panel close button
	input  wire logic               cmd_dir,              // Master direction level, high opens
	input  wire logic               cmd_steps,            // Master step pulses
	input  wire logic               preset1_req,          // Master request for first preset
	input  wire logic               preset2_req,          // Master request for second preset
	input  wire logic               cmd_abs_valid,        // Master absolute target strobe
	input  wire logic [POS_W-1:0]   cmd_abs_pos,          // Master absolute target
	input  wire logic               home_found,           // Encoder reference mark seen
	input  wire logic               fault_detect,         // Error event, one cycle
	input  wire logic               fault_ack,            // Error acknowledge, one cycle
	output logic                    motor_step,           // One-cycle step pulse to the driver
	output logic                    motor_dir,            // Step direction, high opens
	output logic                    fault_status,         // Error present in automatic mode
	output logic                    closed_status,        // At the closed end
	output logic                    open_status,          // At the open end
	output logic                    first_preset_status,  // At the first preset
	output logic                    second_preset_status, // At the second preset
	output logic                    unresponsive_status,  // External control ignored
	output logic                    unresponsive_indicator, // Matching panel lamp
	output logic                    led_manual,           // Manual mode lamp
	output logic                    led_auto,             // Automatic mode lamp
	output logic                    ref_busy              // Reference run in progress
);
	import spm_pkg::*;

	localparam int SW = $clog2(STEP_CYC + 1);
	// Closed end at the position width, so narrow builds cut nothing by accident
	localparam logic [POS_W-1:0] CLOSED_POS = POS_W'(`SPM_CLOSED_POS);

	typedef struct packed {
		spm_state_t       state;
		logic             init;
		logic             auto_md;
		logic             sw_prev;
		logic             lock;
		logic             mixer;
		logic [POS_W-1:0] preset1;
		logic [POS_W-1:0] preset2;
		logic [POS_W-1:0] pos;
		logic [POS_W-1:0] target;
		logic [SW-1:0]    tick_cnt;
		logic             steps_prev;
		logic             err;
		logic             step;
		logic             dir;
		logic             fault_o;
		logic [`SPM_NUM_CMP-1:0] hit_o;
		logic             unresp_o;
		logic             led_man_o;
		logic             led_auto_o;
		logic             ref_o;
	} spm_ctrl_state_t;

	spm_ctrl_state_t s_r;
	spm_ctrl_state_t s_nxt;

	if (STEP_CYC < 2 || POS_W < 2) begin : g_chk
		$error("spm_ctrl: STEP_CYC and POS_W must be at least 2");
	end

	// An empty travel range leaves nothing to position
	if (OPEN_POS <= CLOSED_POS) begin : g_chk_open
		$error("spm_ctrl: OPEN_POS must lie above the closed end");
	end

	// Long reset input filter
	spm_rst_if rif ();
	assign rif.level = ext_reset;

	spm_rst_filter #(
		.HOLD_CYC (HOLD_CYC)
	) u_rst_filter (
		.mclk  (mclk),
		.rst_n (rst_n),
		.port  (rif)
	);

	// Position comparators, one per end and preset status output
	logic [`SPM_NUM_CMP-1:0][POS_W-1:0] cmp_ref;
	logic [`SPM_NUM_CMP-1:0]            cmp_hit;

	assign cmp_ref[`SPM_IDX_CLOSED] = CLOSED_POS;
	assign cmp_ref[`SPM_IDX_OPEN]   = OPEN_POS;
	assign cmp_ref[`SPM_IDX_P1]     = s_r.preset1;
	assign cmp_ref[`SPM_IDX_P2]     = s_r.preset2;

	for (genvar i = 0; i < `SPM_NUM_CMP; i++) begin : g_cmp
		spm_cmp_if #(.POS_W(POS_W)) cif ();
		assign cif.pos     = s_r.pos;
		assign cif.ref_pos = cmp_ref[i];
		assign cmp_hit[i]  = cif.hit;
		spm_pos_match u_match (
			.port (cif)
		);
	end

	// Clamp an absolute target into the travel range
	function automatic logic [POS_W-1:0] clamp_pos(input logic [POS_W-1:0] p);
		clamp_pos = (p > OPEN_POS) ? OPEN_POS : p; // [R23]
	endfunction

	// Target the master control asks for; first preset wins over second
	function automatic logic [POS_W-1:0] master_target(input spm_ctrl_state_t s);
		if (preset1_req) begin
			master_target = clamp_pos(s.preset1); // [R22]
		end else if (preset2_req) begin
			master_target = clamp_pos(s.preset2);
		end else begin
			master_target = clamp_pos(cmd_abs_pos);
		end
	endfunction

	logic tick;
	logic run_ok;
	logic steps_rise;

	assign tick       = (s_r.tick_cnt == SW'(STEP_CYC - 1));
	// Master inputs count only in automatic, after the reference, without error
	assign run_ok     = s_r.auto_md && (s_r.state == SPM_RUN) && !s_r.err; // [R11] [R19]
	assign steps_rise = cmd_steps && !s_r.steps_prev;

	// Next-state logic of the whole controller
	always_comb begin
		s_nxt            = s_r;
		s_nxt.step       = 1'b0;
		s_nxt.steps_prev = cmd_steps;
		s_nxt.tick_cnt   = tick ? '0 : s_r.tick_cnt + SW'(1);

		// Mode selection; the first cycle after reset takes the switch as is
		if (s_r.init) begin
			s_nxt.init    = 1'b0;
			s_nxt.auto_md = mode_switch_auto;
			s_nxt.sw_prev = mode_switch_auto;
		end else begin
			s_nxt.sw_prev = mode_switch_auto;
			if (!s_r.lock && (mode_switch_auto != s_r.sw_prev)) begin
				s_nxt.auto_md = mode_switch_auto; // [R9]
			end
			if (tool_mode_set) begin
				s_nxt.auto_md = tool_mode_auto; // [R8]
			end
		end

		// Settings only land while in manual mode
		if (cfg_wr && !s_r.auto_md) begin // [R13] [R15]
			case (cfg_sel)
				SPM_CFG_PRESET1: s_nxt.preset1 = cfg_data;
				SPM_CFG_PRESET2: s_nxt.preset2 = cfg_data;
				SPM_CFG_MIXER:   s_nxt.mixer   = cfg_data[0];
				SPM_CFG_LOCK:    s_nxt.lock    = cfg_data[0];
				default:         s_nxt.lock    = s_r.lock;
			endcase
		end

		// Error is sticky; a new event in the clearing cycle still wins
		s_nxt.err = fault_detect || (s_r.err && !(fault_ack || rif.pulse)); // [R2] [R21]

		case (s_r.state)
			// Drive toward closed until the reference mark is seen
			SPM_REF_SEEK: begin
				if (tick) begin
					if (home_found) begin
						s_nxt.pos   = CLOSED_POS;
						s_nxt.state = SPM_REF_DONE;
					end else begin
						s_nxt.step = 1'b1;
						s_nxt.dir  = `SPM_DIR_CLOSE;
					end
				end
			end
			// Choose where to go once the position is known
			SPM_REF_DONE: begin
				if (s_r.auto_md) begin
					s_nxt.target = master_target(s_r); // [R17]
				end else begin
					s_nxt.target = s_r.mixer ? OPEN_POS : CLOSED_POS; // [R18]
				end
				s_nxt.state = SPM_RUN;
			end
			SPM_RUN: begin
				if (run_ok) begin
					if (preset1_req || preset2_req || cmd_abs_valid) begin
						s_nxt.target = master_target(s_r); // [R14]
					end else if (steps_rise) begin
						if (cmd_dir && (s_r.target < OPEN_POS)) begin
							s_nxt.target = s_r.target + POS_W'(1); // [R23]
						end else if (!cmd_dir && (s_r.target != `SPM_CLOSED_POS)) begin
							s_nxt.target = s_r.target - POS_W'(1);
						end
					end
				end else if (!s_r.auto_md && tick) begin
					// Buttons jog the target; both pressed means no move
					if (btn_open && !btn_close && (s_r.target < OPEN_POS)) begin
						s_nxt.target = s_r.target + POS_W'(1); // [R12]
					end else if (btn_close && !btn_open && (s_r.target != `SPM_CLOSED_POS)) begin
						s_nxt.target = s_r.target - POS_W'(1);
					end
				end
				// One step per tick toward the target, never past an end
				if (tick && (s_r.pos != s_r.target)) begin
					s_nxt.step = 1'b1;
					if (s_r.pos < s_r.target) begin
						s_nxt.dir = `SPM_DIR_OPEN;
						s_nxt.pos = s_r.pos + POS_W'(1);
					end else begin
						s_nxt.dir = `SPM_DIR_CLOSE;
						s_nxt.pos = s_r.pos - POS_W'(1);
					end
				end
			end
			default: begin
				s_nxt.state = SPM_REF_SEEK;
			end
		endcase

		// Tool request or an accepted long reset restarts the reference
		if (tool_ref_run || rif.pulse) begin
			s_nxt.state = SPM_REF_SEEK; // [R20] [R21]
			s_nxt.step  = 1'b0;
		end

		// Registered status view of the state just computed, except the hits, which come from the current position
		s_nxt.fault_o    = s_nxt.err && s_nxt.auto_md; // [R1]
		s_nxt.hit_o      = cmp_hit; // [R3] [R4] [R5] [R6]
		s_nxt.unresp_o   = !s_nxt.auto_md || (s_nxt.state != SPM_RUN) || s_nxt.err; // [R7] [R19]
		s_nxt.led_man_o  = !s_nxt.auto_md; // [R10]
		s_nxt.led_auto_o = s_nxt.auto_md;
		// Busy flag kept in a flop so the port is not a decode of the state
		s_nxt.ref_o      = (s_nxt.state != SPM_RUN); // [R19]
		// Compares lag the position by one cycle; a step pulse sees the old end flag
	end

	// Reset lands in the reference run, manual, with defaults
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r            <= '0;
			s_r.state      <= SPM_REF_SEEK; // [R16]
			s_r.init       <= 1'b1;
			s_r.preset1    <= POS_W'(`SPM_PRESET1_RST);
			s_r.preset2    <= POS_W'(`SPM_PRESET2_RST);
			s_r.unresp_o   <= 1'b1;
			s_r.ref_o      <= 1'b1;
			s_r.led_man_o  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign motor_step             = s_r.step;
	assign motor_dir              = s_r.dir;
	assign fault_status           = s_r.fault_o;
	assign closed_status          = s_r.hit_o[`SPM_IDX_CLOSED];
	assign open_status            = s_r.hit_o[`SPM_IDX_OPEN];
	assign first_preset_status    = s_r.hit_o[`SPM_IDX_P1];
	assign second_preset_status   = s_r.hit_o[`SPM_IDX_P2];
	assign unresponsive_status    = s_r.unresp_o;
	assign unresponsive_indicator = s_r.unresp_o;
	assign led_manual             = s_r.led_man_o;
	assign led_auto               = s_r.led_auto_o;
	assign ref_busy               = s_r.ref_o;
endmodule

// ### spm_params.svh
// Constants of the stepper positioning control block
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

`define SPM_CLK_PERIOD_NS 10
`define SPM_RST_HOLD_MS   50
`define SPM_RST_HOLD_CYC  ((`SPM_RST_HOLD_MS * 1000000) / `SPM_CLK_PERIOD_NS)
`define SPM_STEP_US       500
`define SPM_STEP_CYC      ((`SPM_STEP_US * 1000) / `SPM_CLK_PERIOD_NS)
`define SPM_POS_W         16
`define SPM_OPEN_POS      16'h0fa0
`define SPM_CLOSED_POS    16'h0000
`define SPM_PRESET1_RST   16'h0000
`define SPM_PRESET2_RST   16'h0000
`define SPM_DIR_OPEN      1'b1
`define SPM_DIR_CLOSE     1'b0
`define SPM_IDX_CLOSED    0
`define SPM_IDX_OPEN      1
`define SPM_IDX_P1        2
`define SPM_IDX_P2        3
`define SPM_NUM_CMP       4

`endif

// ### spm_pkg.sv
// Types shared by the stepper positioning control block
package spm_pkg;
	typedef enum logic [1:0] {
		SPM_REF_SEEK,
		SPM_REF_DONE,
		SPM_RUN
	} spm_state_t;

	typedef enum logic [1:0] {
		SPM_CFG_PRESET1,
		SPM_CFG_PRESET2,
		SPM_CFG_MIXER,
		SPM_CFG_LOCK
	} spm_cfg_sel_t;
endpackage

// ### spm_if.sv
// Carriers between the control block and its helper modules
interface spm_cmp_if #(parameter int POS_W = 16);
	logic [POS_W-1:0] pos;     // Current motor position
	logic [POS_W-1:0] ref_pos; // Position to compare against
	logic             hit;     // Positions are equal
	modport cmp (input pos, input ref_pos, output hit);
	modport user (output pos, output ref_pos, input hit);
endinterface

interface spm_rst_if;
	logic level; // Raw reset input level
	logic pulse; // One cycle once the level has been held long enough
	modport filt (input level, output pulse);
	modport user (output level, input pulse);
endinterface

// ### spm_pos_match.sv
// Equality check of the motor position against one reference
module spm_pos_match (
	spm_cmp_if.cmp port // Position, reference and match flag
);
	import spm_pkg::*;

	// Pure compare, registered by the user so outputs stay glitch free
	always_comb begin
		port.hit = (port.pos == port.ref_pos);
	end
endmodule

// ### spm_rst_filter.sv
// Hold-time filter for the external reset input
`include "spm_params.svh"
module spm_rst_filter #(
	parameter int HOLD_CYC = `SPM_RST_HOLD_CYC
) (
	input  wire logic mclk,    // System clock
	input  wire logic rst_n,   // Asynchronous reset, active low
	spm_rst_if.filt   port     // Level in, accepted pulse out
);
	import spm_pkg::*;

	localparam int CW = $clog2(HOLD_CYC + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          fired;
		logic          pulse;
	} spm_rf_state_t;

	spm_rf_state_t s_r;
	spm_rf_state_t s_nxt;

	if (HOLD_CYC < 2) begin : g_chk
		$error("spm_rst_filter: HOLD_CYC must be at least 2");
	end

	// Count the high time; fire once per held level, short pulses die out
	always_comb begin
		s_nxt       = s_r;
		s_nxt.pulse = 1'b0;
		if (!port.level) begin
			s_nxt.cnt   = '0;
			s_nxt.fired = 1'b0;
		end else if (!s_r.fired) begin
			if (s_r.cnt == CW'(HOLD_CYC - 1)) begin
				s_nxt.pulse = 1'b1; // [R21]
				s_nxt.fired = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign port.pulse = s_r.pulse;
endmodule

// ### spm_ctrl_checker.sv
// Port-level assertions for the stepper positioning control block
module spm_ctrl_checker (
	input wire logic mclk,                   // Clock
	input wire logic rst_n,                  // Reset, active low
	input wire logic fault_detect,           // Error event
	input wire logic fault_ack,              // Error acknowledge
	input wire logic tool_mode_set,          // Tool mode strobe
	input wire logic motor_step,             // Step pulse
	input wire logic motor_dir,              // Step direction
	input wire logic fault_status,           // Fault output
	input wire logic closed_status,          // Closed end output
	input wire logic open_status,            // Open end output
	input wire logic unresponsive_status,    // Ignoring master output
	input wire logic unresponsive_indicator, // Ignoring master lamp
	input wire logic led_manual,             // Manual lamp
	input wire logic led_auto,               // Automatic lamp
	input wire logic ref_busy                // Reference run flag
);
	timeunit 1ns;
	timeprecision 1ps;

	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Fault output and its cause
	property p_fault_auto; fault_status |-> led_auto; endproperty
	a_fault_auto: assert property (p_fault_auto) else $error("fault shown in manual mode");
	property p_fault_set; fault_detect && led_auto && !fault_ack && !tool_mode_set |-> ##[1:2] fault_status; endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault output missing");

	// Mode lamps and the ignoring-master outputs
	property p_lamps; led_manual ^ led_auto; endproperty
	a_lamps: assert property (p_lamps) else $error("mode lamps not exclusive");
	property p_unresp_man; led_manual |-> unresponsive_status; endproperty
	a_unresp_man: assert property (p_unresp_man) else $error("manual mode not flagged");
	property p_unresp_ref; ref_busy && $past(ref_busy) |-> unresponsive_status; endproperty
	a_unresp_ref: assert property (p_unresp_ref) else $error("reference run not flagged");
	property p_lamp_ind; unresponsive_indicator == unresponsive_status; endproperty
	a_lamp_ind: assert property (p_lamp_ind) else $error("lamp differs from output");
	property p_auto_live;
		led_auto && $past(led_auto) && !ref_busy && !$past(ref_busy) && !fault_status |-> !unresponsive_status;
	endproperty
	a_auto_live: assert property (p_auto_live) else $error("automatic mode flagged as ignoring");

	// Motion: seek only closes, end positions are never passed
	property p_seek_dir; ref_busy && $past(ref_busy) && motor_step |-> !motor_dir; endproperty
	a_seek_dir: assert property (p_seek_dir) else $error("seek step opened");
	property p_closed_stop; !ref_busy && motor_step && closed_status |-> motor_dir; endproperty
	a_closed_stop: assert property (p_closed_stop) else $error("step past closed end");
	property p_open_stop; !ref_busy && motor_step && open_status |-> !motor_dir; endproperty
	a_open_stop: assert property (p_open_stop) else $error("step past open end");
endmodule

bind spm_ctrl spm_ctrl_checker chk (.mclk, .rst_n, .fault_detect, .fault_ack, .tool_mode_set, .motor_step,
	.motor_dir, .fault_status, .closed_status, .open_status, .unresponsive_status, .unresponsive_indicator,
	.led_manual, .led_auto, .ref_busy);

// ### spm_motor_model.sv
// Stepper motor with encoder reference mark, seen from the control block
module spm_motor_model #(
	parameter int START = 5
) (
	input wire logic mclk,       // Clock
	input wire logic motor_step, // Step pulse
	input wire logic motor_dir,  // High opens
	output logic     home_found  // Reference mark
);
	timeunit 1ns;
	timeprecision 1ps;
	int phys = START;

	// Shaft keeps its place through resets, like real mechanics
	always @(posedge mclk) begin
		if (motor_step) begin
			phys <= motor_dir ? phys + 1 : phys - 1;
		end
	end

	// Mark is visible only at the closed end
	assign home_found = (phys == 0);
endmodule

// ### test_stepper_position_mode_control.sv
// Self-checking bench of the stepper positioning control block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module test_stepper_position_mode_control;
	timeunit 1ns;
	timeprecision 1ps;
	import spm_pkg::*;
	localparam int CL = 0, OP = 1, P1 = 2, P2 = 3, FS = 4, UN = 5, AU = 6, RB = 7;
	logic         mclk = 1'b0;
	logic         rst_n = 1'b0;
	logic         ext_reset = 1'b0;
	logic         mode_switch_auto = 1'b0;
	logic         tool_mode_auto = 1'b0;
	logic         btn_open = 1'b0;
	logic         btn_close = 1'b0;
	logic         cmd_dir = 1'b1;
	logic         preset1_req = 1'b0;
	logic         preset2_req = 1'b0;
	logic [6:0]   strb = 7'h00;
	logic [15:0]  cfg_data = 16'h0000;
	logic [15:0]  cmd_abs_pos = 16'h0000;
	spm_cfg_sel_t cfg_sel = SPM_CFG_PRESET1;
	wire          home_found, motor_step, motor_dir, fault_status, closed_status, open_status, ref_busy;
	wire          first_preset_status, second_preset_status, unresponsive_status, unresponsive_indicator;
	wire          led_manual, led_auto;
	wire [7:0]    st = {ref_busy, led_auto, unresponsive_status, fault_status, second_preset_status,
		first_preset_status, open_status, closed_status};
	int           error_cnt = 0;
	int           check_count = 0;

	// Short counts keep the run brief
	spm_ctrl #(.OPEN_POS(16'h0008), .STEP_CYC(4), .HOLD_CYC(20)) uut (.mclk, .rst_n, .ext_reset,
		.mode_switch_auto, .tool_mode_set(strb[0]), .tool_mode_auto, .tool_ref_run(strb[1]), .cfg_wr(strb[2]),
		.cfg_sel, .cfg_data, .btn_open, .btn_close, .cmd_dir, .cmd_steps(strb[6]), .preset1_req, .preset2_req,
		.cmd_abs_valid(strb[3]), .cmd_abs_pos, .home_found, .fault_detect(strb[4]), .fault_ack(strb[5]),
		.motor_step, .motor_dir, .fault_status, .closed_status, .open_status, .first_preset_status,
		.second_preset_status, .unresponsive_status, .unresponsive_indicator, .led_manual, .led_auto, .ref_busy);
	spm_motor_model #(.START(5)) motor (.mclk, .motor_step, .motor_dir, .home_found);

	// Clock
	always #5 mclk = ~mclk;

	// Access tasks: strobes, settings, waits
	task automatic pulse(input int i);
		@(posedge mclk) strb[i] <= 1'b1;
		@(posedge mclk) strb[i] <= 1'b0;
	endtask
	task automatic cfg(input spm_cfg_sel_t s, input logic [15:0] d);
		@(posedge mclk) cfg_sel <= s;
		cfg_data <= d;
		pulse(2);
	endtask
	task automatic tool(input logic a);
		@(posedge mclk) tool_mode_auto <= a;
		pulse(0);
	endtask
	task automatic run(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wait_st(input int b, input logic v);
		int n;
		#1;
		n = 0;
		while (st[b] !== v && n < 400) begin
			run(1);
			n++;
		end
		`CHK(st[b], v)
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog sized well above the expected few hundred cycles
	initial begin
		run(20000);
		error_cnt++;
		tally_and_finish;
	end

	// Test sequence
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		run(1);
		`CHK(st[RB], 1'b1)
		wait_st(RB, 1'b0);
		run(20);
		`CHK(st[CL], 1'b1)
		`CHK({led_manual, led_auto}, 2'b10)
		`CHK(st[UN], 1'b1)
		$display("test power_up done");
		cfg(SPM_CFG_PRESET1, 16'h0002);
		cfg(SPM_CFG_PRESET2, 16'h0003);
		@(posedge mclk) btn_open <= 1'b1;
		wait_st(P1, 1'b1);
		wait_st(P2, 1'b1);
		wait_st(OP, 1'b1);
		run(20);
		`CHK(st[OP], 1'b1)
		@(posedge mclk) btn_open <= 1'b0;
		pulse(3);
		run(20);
		`CHK(st[OP], 1'b1)
		$display("test manual done");
		tool(1'b1);
		run(2);
		`CHK(st[AU], 1'b1)
		`CHK(st[UN], 1'b0)
		cfg(SPM_CFG_PRESET1, 16'h0006);
		@(posedge mclk) btn_close <= 1'b1;
		run(20);
		`CHK(st[OP], 1'b1)
		@(posedge mclk) btn_close <= 1'b0;
		cmd_abs_pos <= 16'h0002;
		pulse(3);
		wait_st(P1, 1'b1);
		run(20);
		`CHK(st[P1], 1'b1)
		pulse(6);
		wait_st(P2, 1'b1);
		@(posedge mclk) preset1_req <= 1'b1;
		preset2_req <= 1'b1;
		wait_st(P1, 1'b1);
		$display("test automatic done");
		pulse(4);
		wait_st(FS, 1'b1);
		run(10);
		`CHK(st[FS], 1'b1)
		pulse(5);
		wait_st(FS, 1'b0);
		pulse(4);
		tool(1'b0);
		run(2);
		`CHK(st[FS], 1'b0)
		tool(1'b1);
		run(2);
		`CHK(st[FS], 1'b1)
		@(posedge mclk) ext_reset <= 1'b1;
		run(10);
		@(posedge mclk) ext_reset <= 1'b0;
		run(5);
		`CHK(st[RB], 1'b0)
		@(posedge mclk) ext_reset <= 1'b1;
		run(22);
		@(posedge mclk) ext_reset <= 1'b0;
		wait_st(RB, 1'b1);
		run(2);
		`CHK(st[FS], 1'b0)
		wait_st(RB, 1'b0);
		wait_st(P1, 1'b1);
		$display("test fault_and_reset done");
		@(posedge mclk) preset1_req <= 1'b0;
		preset2_req <= 1'b0;
		tool(1'b0);
		cfg(SPM_CFG_LOCK, 16'h0001);
		@(posedge mclk) mode_switch_auto <= 1'b1;
		run(3);
		`CHK(st[AU], 1'b0)
		cfg(SPM_CFG_LOCK, 16'h0000);
		@(posedge mclk) mode_switch_auto <= 1'b0;
		run(3);
		@(posedge mclk) mode_switch_auto <= 1'b1;
		run(3);
		`CHK(st[AU], 1'b1)
		@(posedge mclk) mode_switch_auto <= 1'b0;
		run(3);
		cfg(SPM_CFG_MIXER, 16'h0001);
		pulse(1);
		wait_st(RB, 1'b1);
		wait_st(RB, 1'b0);
		wait_st(OP, 1'b1);
		$display("test switch_and_mixer done");
		tally_and_finish;
	end
endmodule
